/* hw/power_mode_wakeup_ctrl.sv */
// Operating mode and wakeup controller
`timescale 1ns/100ps
module power_mode_wakeup_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic [power_mode_pkg::PORT_ZERO_WIDTH-1:0] port_zero,
    input wire logic port_one,
    input wire logic basic_timer_ovf,
    input wire logic timer_counter_zero_ovf,
    input wire logic hosc_tick,
    output logic cpu_run,
    output logic sys_clk_low,
    output logic high_osc_on,
    output logic low_osc_on
);
    // ==========================================
    // State
    power_mode_pkg::pm_state_type state_reg, state_next;
    logic [1:0] opmode_reg, opmode_next;
    logic clock_mode_select_reg, clock_mode_select_next;
    logic high_osc_stop_reg, high_osc_stop_next;
    logic basic_timer_enable_reg, basic_timer_enable_next;
    logic pin_one_zero_wake_en_reg, pin_one_zero_wake_en_next;
    logic [power_mode_pkg::PORT_ZERO_WIDTH-1:0] p0_last_reg;
    logic p1_last_reg;
    logic [7:0] rdata_reg, rdata_next;
    logic cpu_run_reg, cpu_run_next;
    logic sys_clk_low_reg, sys_clk_low_next;
    logic high_osc_on_reg, high_osc_on_next;
    logic low_osc_on_reg, low_osc_on_next;
    logic pin_wake;
    logic timer_wake;
    logic osc_wr;
    settle_if sif ();

    settle_counter u_settle (
        .clk(clk),
        .rst_n(rst_n),
        .hosc_tick(hosc_tick),
        .sif(sif)
    );

    // ==========================================
    // Wake sources
    // Port zero has no enable gate at all, so floating pins cause wakeups
    always_comb begin
        pin_wake = (port_zero != p0_last_reg);
        if (pin_one_zero_wake_en_reg && (port_one != p1_last_reg)) begin
            pin_wake = 1'b1;
        end
        timer_wake = (basic_timer_enable_reg && basic_timer_ovf) || timer_counter_zero_ovf;
    end

    assign osc_wr = wr_en && (addr == power_mode_pkg::OSC_MODE_ADDR);

    // ==========================================
    // Mode state machine
    always_comb begin
        state_next = state_reg;
        opmode_next = opmode_reg;
        clock_mode_select_next = clock_mode_select_reg;
        high_osc_stop_next = high_osc_stop_reg;
        basic_timer_enable_next = basic_timer_enable_reg;
        pin_one_zero_wake_en_next = pin_one_zero_wake_en_reg;
        sif.clear = 1'b0;
        sif.count_en = 1'b0;
        case (state_reg)
            power_mode_pkg::RUN: begin
                if (osc_wr) begin
                    clock_mode_select_next = wdata[power_mode_pkg::CLOCK_MODE_SELECT_BIT];
                    high_osc_stop_next = wdata[power_mode_pkg::HIGH_OSC_STOP_BIT];
                    basic_timer_enable_next = wdata[power_mode_pkg::BASIC_TIMER_ENABLE_BIT];
                    opmode_next = {wdata[power_mode_pkg::OPMODE_HIGH_BIT], wdata[power_mode_pkg::OPMODE_LOW_BIT]};
                    // Low bit wins over high bit; reserved 11 is treated as sleep
                    if (wdata[power_mode_pkg::OPMODE_LOW_BIT]) begin
                        state_next = power_mode_pkg::SLEEPING;
                        sif.clear = 1'b1;
                    end else if (wdata[power_mode_pkg::OPMODE_HIGH_BIT]) begin
                        state_next = power_mode_pkg::GREEN_HALT;
                    end
                end
                if (wr_en && (addr == power_mode_pkg::PORT_ONE_WAKE_ENABLE_ADDR)) begin
                    pin_one_zero_wake_en_next = wdata[power_mode_pkg::PIN_ONE_ZERO_WAKE_EN_BIT];
                end
            end
            power_mode_pkg::SLEEPING: begin
                // Timers are ignored here; only pins end sleep
                if (pin_wake) begin
                    state_next = power_mode_pkg::SETTLING;
                end
            end
            power_mode_pkg::SETTLING: begin
                sif.count_en = 1'b1;
                if (sif.done) begin
                    state_next = power_mode_pkg::RUN;
                    opmode_next = power_mode_pkg::MODE_NORMAL;
                    clock_mode_select_next = 1'b0;
                    high_osc_stop_next = 1'b0;
                end
            end
            power_mode_pkg::GREEN_HALT: begin
                if (pin_wake || timer_wake) begin
                    state_next = power_mode_pkg::RUN;
                    opmode_next = power_mode_pkg::MODE_NORMAL;
                end
            end
            default: begin
                state_next = power_mode_pkg::RUN;
            end
        endcase
    end

    // ==========================================
    // Outputs and read data
    always_comb begin
        cpu_run_next = (state_next == power_mode_pkg::RUN);
        sys_clk_low_next = clock_mode_select_next;
        low_osc_on_next = (state_next != power_mode_pkg::SLEEPING);
        // Settling restarts the oscillator even with the stop bit set, else the count never ends
        high_osc_on_next = (state_next == power_mode_pkg::SETTLING)
            || (!high_osc_stop_next && (state_next != power_mode_pkg::SLEEPING));
        rdata_next = 8'h00;
        if (rd_en && (addr == power_mode_pkg::OSC_MODE_ADDR)) begin
            rdata_next[power_mode_pkg::OPMODE_HIGH_BIT] = opmode_reg[1];
            rdata_next[power_mode_pkg::OPMODE_LOW_BIT] = opmode_reg[0];
            rdata_next[power_mode_pkg::CLOCK_MODE_SELECT_BIT] = clock_mode_select_reg;
            rdata_next[power_mode_pkg::HIGH_OSC_STOP_BIT] = high_osc_stop_reg;
            rdata_next[power_mode_pkg::BASIC_TIMER_ENABLE_BIT] = basic_timer_enable_reg;
        end else if (rd_en && (addr == power_mode_pkg::WAKE_STATUS_ADDR)) begin
            rdata_next[1:0] = state_reg;
        end
        // Port one enable is write-only and reads as zero
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= power_mode_pkg::RUN;
            opmode_reg <= power_mode_pkg::MODE_NORMAL;
            clock_mode_select_reg <= 1'b0;
            high_osc_stop_reg <= 1'b0;
            basic_timer_enable_reg <= 1'b0;
            pin_one_zero_wake_en_reg <= power_mode_pkg::PORT_ONE_WAKE_RESET;
            p0_last_reg <= '0;
            p1_last_reg <= 1'b0;
            rdata_reg <= 8'h00;
            cpu_run_reg <= 1'b1;
            sys_clk_low_reg <= 1'b0;
            high_osc_on_reg <= 1'b1;
            low_osc_on_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            opmode_reg <= opmode_next;
            clock_mode_select_reg <= clock_mode_select_next;
            high_osc_stop_reg <= high_osc_stop_next;
            basic_timer_enable_reg <= basic_timer_enable_next;
            pin_one_zero_wake_en_reg <= pin_one_zero_wake_en_next;
            p0_last_reg <= port_zero;
            p1_last_reg <= port_one;
            rdata_reg <= rdata_next;
            cpu_run_reg <= cpu_run_next;
            sys_clk_low_reg <= sys_clk_low_next;
            high_osc_on_reg <= high_osc_on_next;
            low_osc_on_reg <= low_osc_on_next;
        end
    end

    assign rdata = rdata_reg;
    assign cpu_run = cpu_run_reg;
    assign sys_clk_low = sys_clk_low_reg;
    assign high_osc_on = high_osc_on_reg;
    assign low_osc_on = low_osc_on_reg;
endmodule : power_mode_wakeup_ctrl

/* hw/power_mode_pkg.sv */
// Constants and types for the power mode and wakeup controller
package power_mode_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] PORT_ONE_WAKE_ENABLE_ADDR = 8'hC0;
    localparam logic [7:0] OSC_MODE_ADDR = 8'hCA;
    localparam logic [7:0] WAKE_STATUS_ADDR = 8'hCB;
    // ==========================================
    // Field positions
    localparam int HIGH_OSC_STOP_BIT = 1;
    localparam int CLOCK_MODE_SELECT_BIT = 2;
    localparam int OPMODE_LOW_BIT = 3;
    localparam int OPMODE_HIGH_BIT = 4;
    localparam int PIN_ONE_ZERO_WAKE_EN_BIT = 0;
    localparam int BASIC_TIMER_ENABLE_BIT = 5;
    // ==========================================
    // Reset values and encodings
    localparam logic [7:0] OSC_MODE_RESET = 8'h00;
    localparam logic PORT_ONE_WAKE_RESET = 1'b0;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_GREEN = 2'h2;
    // ==========================================
    // Timing
    localparam int SETTLE_CYCLES = 2048;
    localparam int SETTLE_WIDTH = 12;
    localparam int PORT_ZERO_WIDTH = 4;
    typedef enum logic [1:0] {RUN, SLEEPING, SETTLING, GREEN_HALT} pm_state_type;
endpackage : power_mode_pkg

/* hw/settle_if.sv */
// Interface between mode controller and settling counter
`timescale 1ns/100ps
interface settle_if;
    logic clear;
    logic count_en;
    logic done;
    modport ctrl (output clear, output count_en, input done);
    modport counter (input clear, input count_en, output done);
endinterface : settle_if

/* hw/settle_counter.sv */
// Oscillator settling counter for sleep wakeup
`timescale 1ns/100ps
module settle_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hosc_tick,
    settle_if.counter sif
);
    logic [power_mode_pkg::SETTLE_WIDTH:0] count_reg, count_next;

    always_comb begin
        count_next = count_reg;
        if (sif.clear) begin
            count_next = '0;
        end else if (sif.count_en && hosc_tick && !sif.done) begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign sif.done = (count_reg == (power_mode_pkg::SETTLE_WIDTH + 1)'(power_mode_pkg::SETTLE_CYCLES));
endmodule : settle_counter

/* testbench/wake_pins_model.sv */
// Wake pins and high oscillator tick source
`timescale 1ns/100ps
module wake_pins_model (
    input wire logic clk, osc_on, flip_zero, flip_one,
    output logic [power_mode_pkg::PORT_ZERO_WIDTH-1:0] port_zero,
    output logic port_one, hosc_tick
);
    // Pull-ups hold idle pins high
    initial {port_zero, port_one, hosc_tick} = {{power_mode_pkg::PORT_ZERO_WIDTH{1'b1}}, 2'b10};
    // Ticks stop while the oscillator is off, so settling cannot run early
    always @(posedge clk) begin
        port_zero[0] <= port_zero[0] ^ flip_zero;
        port_one <= port_one ^ flip_one;
        hosc_tick <= osc_on && !hosc_tick;
    end
endmodule : wake_pins_model

/* testbench/power_mode_wakeup_ctrl_chk.sv */
// Port assertions for the power mode controller
`timescale 1ns/100ps
module power_mode_wakeup_ctrl_chk (
    input wire logic clk, rst_n, wr_en, port_one, timer_counter_zero_ovf, hosc_tick,
    input wire logic cpu_run, sys_clk_low, high_osc_on, low_osc_on,
    input wire logic [7:0] addr, wdata,
    input wire logic [power_mode_pkg::PORT_ZERO_WIDTH-1:0] port_zero
);
    logic mw, in_green, in_sleep, asleep;
    logic [12:0] ticks;
    assign mw = wr_en && addr == power_mode_pkg::OSC_MODE_ADDR && cpu_run;
    assign asleep = in_sleep && !high_osc_on;
    // Mode seen from the ports; writes count only while running
    always_ff @(posedge clk) begin
        in_green <= rst_n && ((mw && wdata[4:3] == 2'h2) || (in_green && !cpu_run));
        in_sleep <= rst_n && ((mw && wdata[3]) || (in_sleep && !cpu_run));
        ticks <= (rst_n && !cpu_run) ? ticks + {12'h0, in_sleep && high_osc_on && hosc_tick} : 13'h0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence settle_done;
        in_sleep && $rose(cpu_run);
    endsequence
    chk_sleep_entry: assert property (mw && wdata[3] |=> !cpu_run && !high_osc_on && !low_osc_on)
        else $error("sleep entry");
    chk_green_entry: assert property (mw && wdata[4:3] == 2'h2 |=> !cpu_run && low_osc_on)
        else $error("green entry");
    chk_clock_select: assert property (mw && wdata[4:3] == 2'h0 |=> sys_clk_low == $past(wdata[2]))
        else $error("clock select");
    chk_osc_stop: assert property (mw && wdata[4:3] == 2'h0 |=> high_osc_on != $past(wdata[1]) && low_osc_on)
        else $error("osc stop");
    chk_green_timer: assert property (in_green && !cpu_run && timer_counter_zero_ovf |=> cpu_run)
        else $error("green wake");
    chk_sleep_hold: assert property (asleep && $stable(port_zero) && $stable(port_one) |=> !cpu_run)
        else $error("sleep hold");
    chk_sleep_pin: assert property (asleep && port_zero != $past(port_zero) |=> high_osc_on && !cpu_run)
        else $error("pin wake");
    chk_settle_count: assert property (settle_done |-> ticks >= 13'h800 && ticks <= 13'h801 && !sys_clk_low)
        else $error("settle count");
endmodule : power_mode_wakeup_ctrl_chk
bind power_mode_wakeup_ctrl power_mode_wakeup_ctrl_chk power_mode_wakeup_ctrl_chk_inst (.clk(clk), .rst_n(rst_n),
    .wr_en(wr_en), .port_one(port_one), .timer_counter_zero_ovf(timer_counter_zero_ovf), .hosc_tick(hosc_tick),
    .cpu_run(cpu_run), .sys_clk_low(sys_clk_low), .high_osc_on(high_osc_on), .low_osc_on(low_osc_on),
    .addr(addr), .wdata(wdata), .port_zero(port_zero));

/* testbench/test_power_mode_wakeup_ctrl.sv */
// Bench for the power mode and wakeup controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
`define OUTS(e) `CHK("outputs", e, {cpu_run, sys_clk_low, high_osc_on, low_osc_on})
module test_power_mode_wakeup_ctrl;
    logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic port_one, hosc_tick, cpu_run, sys_clk_low, high_osc_on, low_osc_on;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [3:0] stim = 4'h0;
    logic [power_mode_pkg::PORT_ZERO_WIDTH-1:0] port_zero;
    int fail_count = 0, n_checks = 0, cycles = 0, w;
    power_mode_wakeup_ctrl power_mode_wakeup_ctrl_inst (.*, .basic_timer_ovf(stim[0]),
        .timer_counter_zero_ovf(stim[1]));
    wake_pins_model wake_pins_model_inst (.clk(clk), .osc_on(high_osc_on), .flip_zero(stim[2]),
        .flip_one(stim[3]), .port_zero(port_zero), .port_one(port_one), .hosc_tick(hosc_tick));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // One bus cycle; a read checks d against the data of the next cycle
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr_en, rd_en} <= {a, d, wr, !wr};
        @(posedge clk);
        {wr_en, rd_en} <= 2'b00;
        #1;
        if (!wr) `CHK("rdata", d, rdata)
    endtask : acc
    // Timer pulses or pin flips, then time for the wake to land
    task automatic poke(input logic [3:0] s);
        @(posedge clk);
        stim <= s;
        @(posedge clk);
        stim <= 4'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask : poke
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `OUTS(4'hB)
        acc(1'b0, 8'hCA, 8'h00);
        acc(1'b0, 8'h55, 8'h00);
        acc(1'b1, 8'hCA, 8'h04);
        `OUTS(4'hF)
        acc(1'b1, 8'hCA, 8'h06);
        `OUTS(4'hD)
        acc(1'b1, 8'hCA, 8'h04);
        repeat (40) @(posedge clk); // Short stand-in for the restart wait
        acc(1'b1, 8'hCA, 8'h00);
        `OUTS(4'hB)
        acc(1'b1, 8'hCA, 8'h14);
        `OUTS(4'h7)
        poke(4'h1);
        `OUTS(4'h7)
        poke(4'h2);
        `OUTS(4'hF)
        acc(1'b0, 8'hCA, 8'h04);
        acc(1'b1, 8'hCA, 8'h34);
        poke(4'h1);
        `OUTS(4'hF)
        acc(1'b1, 8'hCA, 8'h0C);
        `OUTS(4'h4)
        poke(4'h3);
        poke(4'h8);
        `OUTS(4'h4)
        poke(4'h4);
        `CHK("settling", 2'b01, {cpu_run, high_osc_on})
        // Look after the edge has settled, not in its own time step
        for (w = 0; w < 5000 && cpu_run !== 1'b1; w++) begin
            @(posedge clk);
            #1;
        end
        `CHK("settle time", 1'b1, w > 4088 && w < 4104)
        `OUTS(4'hB)
        acc(1'b0, 8'hCA, 8'h00);
        acc(1'b1, 8'hC0, 8'h01);
        acc(1'b0, 8'hC0, 8'h00);
        acc(1'b1, 8'hCA, 8'h10);
        poke(4'h8);
        `OUTS(4'hB)
        close_out();
    end
endmodule : test_power_mode_wakeup_ctrl
